// >>> rtl/sncp_pkg.sv
// constants, register map and helpers for the serial/network connection packer
package sncp_pkg;
  // timing base
  localparam int CLK_PERIOD_NS  = 4;
  localparam int MS_NS          = 1000000;
  localparam int MS_CYCLES_DFLT = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_W           = 18;
  localparam int SEC_MS         = 1000;
  localparam int CNT_W          = 13;
  localparam logic [CNT_W-1:0] IVL_12_MS    = 13'h000C;
  localparam logic [CNT_W-1:0] IVL_52_MS    = 13'h0034;
  localparam logic [CNT_W-1:0] IVL_250_MS   = 13'h00FA;
  localparam logic [CNT_W-1:0] IVL_5000_MS  = 13'h1388;
  localparam logic [CNT_W-1:0] LED_HALF_MS  = 13'h00FA;
  localparam logic [CNT_W-1:0] CLOSE_WAIT_MS = 13'h03E8;
  localparam logic [CNT_W-1:0] SEC_MS_M1    = 13'h03E7;
  localparam logic [CNT_W-1:0] TMO_MAX_S    = 13'h176F;
  // apb register offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DISC  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLUSH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PACK  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TMO   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SCHAR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] CFG_RST = 8'h00;
  // disconnect_config bits
  localparam int DC_MDM = 7, DC_TELNET = 6, DC_EOT = 5, DC_PWD = 4, DC_NOHARD = 3, DC_LEDOFF = 0;
  // buffer_flush_config bits
  localparam int FL_N2S_DEV = 0, FL_N2S_NET = 1, FL_N2S_DIS = 2;
  localparam int FL_S2N_DEV = 4, FL_S2N_NET = 5, FL_S2N_DIS = 6, FL_ALT = 7;
  // pack_control_config bits
  localparam int PK_IVL = 0, PK_TRL = 2, PK_SEQ = 4, PK_IMM = 5;
  localparam logic [7:0] EOT_CHAR = 8'h04;
  localparam logic [7:0] SC_OFF   = 8'h00;
  typedef enum logic {CL_IDLE, CL_WAIT} sncp_close_t;
  // packing wait in ms from the two interval bits
  function automatic logic [CNT_W-1:0] sncp_ivl_ms(input logic [1:0] code);
    case (code)
      2'h0:    sncp_ivl_ms = IVL_12_MS;
      2'h1:    sncp_ivl_ms = IVL_52_MS;
      2'h2:    sncp_ivl_ms = IVL_250_MS;
      default: sncp_ivl_ms = IVL_5000_MS;
    endcase
  endfunction : sncp_ivl_ms
  // trailing characters wanted after a match; code 3 treated as none
  function automatic logic [1:0] sncp_trail(input logic [1:0] code);
    sncp_trail = (code == 2'h3) ? 2'h0 : code;
  endfunction : sncp_trail
endpackage : sncp_pkg

// >>> rtl/sncp_top.sv
// serial/network connection packer: disconnect, flush and packing control
`timescale 1ns/1ps
// Contract
// R1 - modem input falling edge drops connection when enabled
// R2 - telnet mode sends terminal type outgoing
// R3 - password demanded for network-side connections
// R4 - hard disconnect closes without remote acknowledge
// R5 - LED held off while connected, if set
// R6 - serial EOT drops connection with telnet+EOT
// R7 - serial-to-network buffer flush on events
// R8 - network-to-serial buffer flush on events
// R9 - flush bit 7 selects alternate packing
// R10 - interval bits pick 12/52/250/5000 ms
// R11 - wait timed between data segments; default 12ms
// R12 - trailing characters after send char: 0/1/2
// R13 - bit 4 matches send chars as pair
// R14 - bit 5 sends immediately, else include buffer
// R15 - inactivity timeout 0..5999 s, 0 disables
// R16 - send char forwards segment with buffered data
// R17 - first send char zero disables matching
// R18 - telnet option enables EOR and binary
// R19 - control segments may bypass packing
// R20 - software writes pack control zero if unused
// R21 - each serial character restarts inactivity timer
module sncp_top
  import sncp_pkg::*;
#(
  parameter int MS_CYCLES = sncp_pkg::MS_CYCLES_DFLT
) (
  input  wire logic                        mclk,
  input  wire logic                        rstn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [sncp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        modem_ctrl_in,
  input  wire logic                        ser_valid,
  input  wire logic [7:0]                  ser_data,
  input  wire logic                        conn_active,
  input  wire logic                        conn_open_dev,
  input  wire logic                        conn_open_net,
  input  wire logic                        tcp_close_ack,
  input  wire logic                        net_ctl_req,
  output logic                             drop_conn,
  output logic                             tcp_abort,
  output logic                             flush_s2n,
  output logic                             flush_n2s,
  output logic                             seg_send,
  output logic                             seg_with_pending,
  output logic                             seg_ctrl,
  output logic                             send_term_type,
  output logic                             telnet_opts_en,
  output logic                             pwd_required,
  output logic                             led_state
);
  import sncp_pkg::*;

  logic [7:0]       disc_q, flush_q, pack_q, sc1_q, sc2_q;
  logic [CNT_W-1:0] tmo_q;
  logic             pready_q, pslverr_q;
  logic [31:0]      prdata_q;
  logic             wr_en;
  logic [31:0]      rd_d;
  logic             hit_d;
  // status sources, declared early since the read mux uses them
  sncp_close_t      cl_q;
  logic             mdm_q, armed_q;
  logic [7:0]       pend_q;

  // apb: data and error prepared in setup, one-cycle access phase
  assign wr_en = psel & penable & pready_q & pwrite;
  always_comb begin
    hit_d = 1'b1;
    rd_d  = 32'h0000_0000;
    case (paddr)
      OFS_DISC:  rd_d[7:0] = disc_q;
      OFS_FLUSH: rd_d[7:0] = flush_q;
      OFS_PACK:  rd_d[7:0] = pack_q;
      OFS_TMO:   rd_d[CNT_W-1:0] = tmo_q;
      OFS_SCHAR: rd_d[15:0] = {sc2_q, sc1_q};
      OFS_STAT:  rd_d[15:0] = {pend_q, 4'h0, cl_q == CL_WAIT, armed_q, mdm_q, conn_active};
      default:   hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit_d;
      if (psel & ~penable & ~pwrite)
        prdata_q <= rd_d;
    end
  end

  // configuration registers, all reset to zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      disc_q  <= CFG_RST;
      flush_q <= CFG_RST;
      pack_q  <= CFG_RST;
      sc1_q   <= CFG_RST;
      sc2_q   <= CFG_RST;
      tmo_q   <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_DISC:  disc_q  <= pwdata[7:0];
        OFS_FLUSH: flush_q <= pwdata[7:0];
        OFS_PACK:  pack_q  <= pwdata[7:0];
        OFS_SCHAR: {sc2_q, sc1_q} <= pwdata[15:0];
        // out-of-range timeouts saturate at the top of the range
        OFS_TMO:   tmo_q <= (pwdata[31:0] > {19'h0, TMO_MAX_S}) ? TMO_MAX_S : pwdata[CNT_W-1:0]; // R15
        default: ;
      endcase
    end
  end

  // ms tick and second tick from one divider chain
  logic [MS_W-1:0]  div_q;
  logic [CNT_W-1:0] msc_q;
  logic             ms_tick, sec_tick;
  assign ms_tick  = (div_q == MS_W'(MS_CYCLES - 1));
  assign sec_tick = ms_tick & (msc_q == SEC_MS_M1);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_q <= '0;
      msc_q <= '0;
    end else begin
      div_q <= ms_tick ? '0 : div_q + 1'b1;
      if (ms_tick)
        msc_q <= sec_tick ? '0 : msc_q + 1'b1;
    end
  end

  // modem control pin: three flops, stable once last two agree
  logic m1_q, m2_q, m3_q, mdm_fall;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      m1_q  <= 1'b1;
      m2_q  <= 1'b1;
      m3_q  <= 1'b1;
      mdm_q <= 1'b1;
    end else begin
      m1_q <= modem_ctrl_in;
      m2_q <= m1_q;
      m3_q <= m2_q;
      if (m2_q == m3_q)
        mdm_q <= m3_q;
    end
  end
  assign mdm_fall = mdm_q & ~m2_q & ~m3_q;

  // inactivity: seconds since the last serial character
  logic [CNT_W-1:0] idle_s_q;
  logic             idle_exp;
  assign idle_exp = sec_tick & (tmo_q != '0) & (idle_s_q + 1'b1 >= tmo_q); // R15
  always_ff @(posedge mclk) begin
    if (!rstn)
      idle_s_q <= '0;
    else if (!conn_active || ser_valid)
      idle_s_q <= '0; // R21
    else if (sec_tick)
      idle_s_q <= idle_s_q + 1'b1;
  end

  // drop requests; eot is only looked for in the serial direction
  logic eot_hit, drop_d;
  assign eot_hit = ser_valid & (ser_data == EOT_CHAR) & disc_q[DC_EOT] & disc_q[DC_TELNET]; // R6
  assign drop_d  = conn_active & ((mdm_fall & disc_q[DC_MDM]) | eot_hit | idle_exp); // R1
  always_ff @(posedge mclk) begin
    if (!rstn)
      drop_conn <= 1'b0;
    else
      drop_conn <= drop_d;
  end

  // close supervision: a hard close aborts if the peer never answers
  logic [CNT_W-1:0] cl_ms_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cl_q      <= CL_IDLE;
      cl_ms_q   <= '0;
      tcp_abort <= 1'b0;
    end else begin
      tcp_abort <= 1'b0;
      unique case (cl_q)
        CL_IDLE: begin
          cl_ms_q <= '0;
          if (drop_d)
            cl_q <= CL_WAIT;
        end
        CL_WAIT: begin
          if (tcp_close_ack || !conn_active) begin
            cl_q <= CL_IDLE;
          end else if (ms_tick) begin
            cl_ms_q <= cl_ms_q + 1'b1;
            if (!disc_q[DC_NOHARD] && cl_ms_q + 1'b1 >= CLOSE_WAIT_MS) begin
              tcp_abort <= 1'b1; // R4
              cl_q      <= CL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // buffer flushes on open by either side and on disconnect
  logic conn_d_q, disc_ev;
  assign disc_ev = conn_d_q & ~conn_active;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      conn_d_q  <= 1'b0;
      flush_s2n <= 1'b0;
      flush_n2s <= 1'b0;
    end else begin
      conn_d_q  <= conn_active;
      flush_s2n <= (conn_open_dev & flush_q[FL_S2N_DEV]) | (conn_open_net & flush_q[FL_S2N_NET])
                 | (disc_ev & flush_q[FL_S2N_DIS]); // R7
      flush_n2s <= (conn_open_dev & flush_q[FL_N2S_DEV]) | (conn_open_net & flush_q[FL_N2S_NET])
                 | (disc_ev & flush_q[FL_N2S_DIS]); // R8
    end
  end

  // telnet and password levels, terminal type on outgoing open
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      send_term_type <= 1'b0;
      telnet_opts_en <= 1'b0;
      pwd_required   <= 1'b0;
    end else begin
      send_term_type <= conn_open_dev & disc_q[DC_TELNET]; // R2
      telnet_opts_en <= disc_q[DC_TELNET]; // R18
      pwd_required   <= disc_q[DC_PWD]; // R3
    end
  end

  // state led blinks, or is held off while a connection exists
  logic [CNT_W-1:0] led_ms_q;
  logic             blink_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      led_ms_q  <= '0;
      blink_q   <= 1'b0;
      led_state <= 1'b0;
    end else begin
      if (ms_tick) begin
        led_ms_q <= (led_ms_q + 1'b1 >= LED_HALF_MS) ? '0 : led_ms_q + 1'b1;
        if (led_ms_q + 1'b1 >= LED_HALF_MS)
          blink_q <= ~blink_q;
      end
      led_state <= (conn_active & disc_q[DC_LEDOFF]) ? 1'b0 : blink_q; // R5
    end
  end

  // packing: interval, send-character match and trailing characters
  logic [CNT_W-1:0] gap_q, ivl;
  logic [7:0]       prev_q;
  logic             prev_vld_q;
  logic [1:0]       trail_q, trail_n;
  logic             sc_en, match, tmo_hit, trail_done, data_send;
  assign ivl     = flush_q[FL_ALT] ? sncp_ivl_ms(pack_q[PK_IVL +: 2]) : IVL_12_MS; // R9 R10 R11
  assign trail_n = flush_q[FL_ALT] ? sncp_trail(pack_q[PK_TRL +: 2]) : 2'h0; // R12
  assign sc_en   = (sc1_q != SC_OFF); // R17
  assign match   = ser_valid & sc_en & ((flush_q[FL_ALT] & pack_q[PK_SEQ])
                 ? (prev_vld_q & (prev_q == sc1_q) & (ser_data == sc2_q)) // R13
                 : ((ser_data == sc1_q) | (ser_data == sc2_q))); // R16
  assign tmo_hit    = (pend_q != '0) & (gap_q >= ivl); // R11
  assign trail_done = armed_q & ser_valid & (trail_q == 2'h1);
  assign data_send  = conn_active & ((match & ~armed_q & (trail_n == 2'h0)) | trail_done | tmo_hit);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prev_q     <= '0;
      prev_vld_q <= 1'b0;
      armed_q    <= 1'b0;
      trail_q    <= '0;
    end else begin
      if (ser_valid) begin
        prev_q     <= ser_data;
        prev_vld_q <= ~match;
      end
      if (data_send) begin
        armed_q <= 1'b0;
      end else if (match & ~armed_q & conn_active) begin
        armed_q <= 1'b1; // R12
        trail_q <= trail_n;
      end else if (armed_q & ser_valid) begin
        trail_q <= trail_q - 1'b1;
      end
    end
  end

  // pending count saturates; the gap runs between data segments
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pend_q <= '0;
      gap_q  <= '0;
    end else begin
      if (data_send)
        pend_q <= '0;
      else if (ser_valid && pend_q != 8'hFF)
        pend_q <= pend_q + 1'b1;
      if (data_send)
        gap_q <= '0; // R11
      else if (ms_tick && gap_q != TMO_MAX_S)
        gap_q <= gap_q + 1'b1;
    end
  end

  // segment strobes; control traffic goes out regardless of packing
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seg_send         <= 1'b0;
      seg_with_pending <= 1'b0;
      seg_ctrl         <= 1'b0;
    end else begin
      seg_send         <= data_send | (conn_active & net_ctl_req); // R19
      seg_ctrl         <= conn_active & net_ctl_req & ~data_send;
      seg_with_pending <= data_send & ~(flush_q[FL_ALT] & pack_q[PK_IMM]); // R14
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_mdm_fall_on;
    conn_active && disc_q[DC_MDM] && mdm_fall;
  endsequence
  property p_mdm_drop;
    s_mdm_fall_on |=> drop_conn;
  endproperty
  a_mdm_drop: assert property (p_mdm_drop) else $error("modem fall did not drop"); // R1
  property p_mdm_ignored;
    !disc_q[DC_MDM] && !eot_hit && !idle_exp |=> !drop_conn;
  endproperty
  a_mdm_ignored: assert property (p_mdm_ignored) else $error("drop without cause"); // R1
  property p_eot_drop;
    conn_active && ser_valid && ser_data == EOT_CHAR && disc_q[DC_EOT] && disc_q[DC_TELNET] |=> drop_conn;
  endproperty
  a_eot_drop: assert property (p_eot_drop) else $error("eot did not drop"); // R6
  property p_term_type;
    conn_open_dev && disc_q[DC_TELNET] |=> send_term_type;
  endproperty
  a_term_type: assert property (p_term_type) else $error("terminal type missing"); // R2
  property p_flush_dis;
    conn_d_q && !conn_active && flush_q[FL_S2N_DIS] && flush_q[FL_N2S_DIS] |=> flush_s2n && flush_n2s;
  endproperty
  a_flush_dis: assert property (p_flush_dis) else $error("disconnect flush missing"); // R7 R8
  property p_led_off;
    conn_active && disc_q[DC_LEDOFF] [*2] |=> !led_state;
  endproperty
  a_led_off: assert property (p_led_off) else $error("led not held off"); // R5
  property p_send_char;
    conn_active && match && !armed_q && trail_n == 2'h0 |=> seg_send && !seg_ctrl;
  endproperty
  a_send_char: assert property (p_send_char) else $error("send char not forwarded"); // R16
  property p_no_sc;
    sc1_q == SC_OFF |-> !match;
  endproperty
  a_no_sc: assert property (p_no_sc) else $error("match while disabled"); // R17
  sequence s_abort_due;
    cl_q == CL_WAIT && !disc_q[DC_NOHARD] && ms_tick && cl_ms_q == CLOSE_WAIT_MS - 1'b1
      && !tcp_close_ack && conn_active;
  endsequence
  property p_hard_abort;
    s_abort_due |=> tcp_abort ##1 !tcp_abort;
  endproperty
  a_hard_abort: assert property (p_hard_abort) else $error("hard close not forced"); // R4
  property p_soft_close;
    disc_q[DC_NOHARD] && $stable(disc_q) |=> !tcp_abort;
  endproperty
  a_soft_close: assert property (p_soft_close) else $error("abort with hard close off"); // R4
  property p_imm;
    data_send && flush_q[FL_ALT] && pack_q[PK_IMM] |=> seg_send && !seg_with_pending;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate send included buffer"); // R14
endmodule : sncp_top

// >>> test/sncp_far_end.sv
// far-side model: attached serial device and remote network host
`timescale 1ns/1ps
module sncp_far_end (
  input  wire logic       mclk,
  output logic            ser_valid,
  output logic [7:0]      ser_data,
  output logic            conn_active,
  output logic            conn_open_dev,
  output logic            conn_open_net,
  output logic            tcp_close_ack,
  output logic            net_ctl_req,
  output logic            modem_ctrl_in
);
  // idle levels; modem line rests high so reset release sees no fall
  initial begin
    ser_valid     = 1'b0;
    ser_data      = 8'hA5;
    conn_active   = 1'b0;
    conn_open_dev = 1'b0;
    conn_open_net = 1'b0;
    tcp_close_ack = 1'b0;
    net_ctl_req   = 1'b0;
    modem_ctrl_in = 1'b1;
  end
  // one character; data is inverted after the strobe so stale bytes never look valid
  task automatic send_char(input logic [7:0] c);
    @(posedge mclk);
    ser_valid <= 1'b1;
    ser_data  <= c;
    @(posedge mclk);
    ser_valid <= 1'b0;
    ser_data  <= ~c;
  endtask : send_char
  // connection opened by the device or by the network
  task automatic open_conn(input logic by_net);
    @(posedge mclk);
    conn_active   <= 1'b1;
    tcp_close_ack <= 1'b0;
    conn_open_net <= by_net;
    conn_open_dev <= ~by_net;
    @(posedge mclk);
    conn_open_net <= 1'b0;
    conn_open_dev <= 1'b0;
  endtask : open_conn
  // connection gone; ack low models a peer that never answers the close
  task automatic close_conn(input logic ack);
    @(posedge mclk);
    conn_active   <= 1'b0;
    tcp_close_ack <= ack;
    @(posedge mclk);
  endtask : close_conn
  // peer needs an acknowledgment segment
  task automatic ctl_req();
    @(posedge mclk);
    net_ctl_req <= 1'b1;
    @(posedge mclk);
    net_ctl_req <= 1'b0;
  endtask : ctl_req
  task automatic modem(input logic v);
    @(posedge mclk);
    modem_ctrl_in <= v;
  endtask : modem
endmodule : sncp_far_end

// >>> test/serial_net_connection_packer_tb_top.sv
// self-checking bench for the serial/network connection packer
`timescale 1ns/1ps
module serial_net_connection_packer_tb_top;
  import sncp_pkg::*;
  localparam int MS = 10;
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ser_valid, conn_active, conn_open_dev, conn_open_net, tcp_close_ack, net_ctl_req, modem_ctrl_in;
  logic [7:0]  ser_data, seen;
  logic        drop_conn, tcp_abort, flush_s2n, flush_n2s, seg_send, seg_with_pending, seg_ctrl;
  logic        send_term_type, telnet_opts_en, pwd_required, led_state, er;
  int          n, ones, n_errors, n_tests;
  logic [7:0]  dcfg [4] = '{8'h88, 8'h08, 8'h68, 8'h28};
  int          ivl  [3] = '{12, 52, 250};
  // event pulses gathered for one watcher
  wire logic [7:0] ev = {tcp_abort, drop_conn, flush_s2n, flush_n2s, seg_send, seg_ctrl, send_term_type,
                         seg_with_pending};
  sncp_top #(.MS_CYCLES(MS)) uut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_ctrl_in(modem_ctrl_in), .ser_valid(ser_valid), .ser_data(ser_data), .conn_active(conn_active),
    .conn_open_dev(conn_open_dev), .conn_open_net(conn_open_net), .tcp_close_ack(tcp_close_ack),
    .net_ctl_req(net_ctl_req), .drop_conn(drop_conn), .tcp_abort(tcp_abort), .flush_s2n(flush_s2n),
    .flush_n2s(flush_n2s), .seg_send(seg_send), .seg_with_pending(seg_with_pending), .seg_ctrl(seg_ctrl),
    .send_term_type(send_term_type), .telnet_opts_en(telnet_opts_en), .pwd_required(pwd_required),
    .led_state(led_state));
  sncp_far_end fm (.mclk(mclk), .ser_valid(ser_valid), .ser_data(ser_data), .conn_active(conn_active),
    .conn_open_dev(conn_open_dev), .conn_open_net(conn_open_net), .tcp_close_ack(tcp_close_ack),
    .net_ctl_req(net_ctl_req), .modem_ctrl_in(modem_ctrl_in));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  // apb transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int g;
    g = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      g++;
    end while (pready !== 1'b1 && g < 16);
    if (g >= 16) check(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wreg
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check({31'h0, er}, {31'h0, ee});
  endtask : rchk
  // first cycle any masked pulse shows, -1 if none within the window
  task automatic watch(input int maxc, input logic [7:0] mask);
    n = -1;
    seen = 8'h00;
    for (int i = 0; i < maxc; i++) begin
      #1;
      if ((ev & mask) != 8'h00) begin
        n = i;
        seen = ev;
        break;
      end
      @(posedge mclk);
    end
  endtask : watch
  task automatic expect_ev(input int maxc, input logic [7:0] mask, input logic e);
    watch(maxc, mask);
    check({31'h0, n >= 0}, {31'h0, e});
  endtask : expect_ev
  task automatic expect_at(input int lo, input int hi, input logic [7:0] mask);
    watch(hi + 1, mask);
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask : expect_at
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // hang guard: planned run is about 72000 cycles, dominated by the second-based timers
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, n_errors, n_tests} = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    // register reset values, masking and refusal
    rchk(OFS_DISC, 32'h0, 1'b0);
    rchk(OFS_FLUSH, 32'h0, 1'b0);
    rchk(OFS_PACK, 32'h0, 1'b0);
    wreg(OFS_PACK, 32'hFFFF_FFA5);
    rchk(OFS_PACK, 32'h0000_00A5, 1'b0);
    wreg(OFS_PACK, 32'h0);
    wreg(OFS_TMO, 32'h0000_1770);
    rchk(OFS_TMO, {19'h0, TMO_MAX_S}, 1'b0);
    wreg(OFS_TMO, 32'h0);
    rchk(8'h40, 32'h0, 1'b1);
    $display("test registers finished");
    // telnet and password options
    wreg(OFS_DISC, 32'h0000_0058);
    repeat (2) @(posedge mclk);
    #1;
    check({31'h0, telnet_opts_en}, 32'h1);
    check({31'h0, pwd_required}, 32'h1);
    fm.open_conn(1'b0);
    expect_ev(3, 8'h02, 1'b1);
    fm.close_conn(1'b1);
    fm.open_conn(1'b1);
    expect_ev(3, 8'h02, 1'b0);
    fm.close_conn(1'b1);
    $display("test options finished");
    // buffer flushes per event, set and cleared
    for (int e = 0; e < 3; e++) begin
      for (int k = 0; k < 2; k++) begin
        wreg(OFS_FLUSH, {24'h0, (k == 0) ? (8'h11 << e) : (8'h77 ^ (8'h11 << e))});
        if (e == 2) fm.open_conn(1'b0);
        if (e == 2) fm.close_conn(1'b1);
        else fm.open_conn(e[0]);
        watch(4, 8'h30);
        check({30'h0, seen[5:4]}, (k == 0) ? 32'h3 : 32'h0);
        if (e != 2) fm.close_conn(1'b1);
      end
    end
    $display("test flush finished");
    // modem fall and end-of-transmission drops, enabled and not
    wreg(OFS_FLUSH, 32'h0);
    fm.open_conn(1'b0);
    for (int j = 0; j < 4; j++) begin
      wreg(OFS_DISC, {24'h0, dcfg[j]});
      if (j < 2) fm.modem(1'b0);
      else fm.send_char(EOT_CHAR);
      expect_ev(8, 8'h40, j == 0 || j == 2);
      fm.modem(1'b1);
      repeat (6) @(posedge mclk);
    end
    // state led blinks while connected unless held off
    for (int j = 0; j < 2; j++) begin
      wreg(OFS_DISC, j ? 32'h9 : 32'h8);
      ones = 0;
      repeat (600 * MS) begin
        @(posedge mclk);
        #1;
        ones += int'(led_state);
      end
      check({31'h0, ones == 0}, {31'h0, j[0]});
    end
    $display("test drop and led finished");
    // standard packing, send characters
    wreg(OFS_SCHAR, 32'h0000_0A0D);
    fm.send_char(8'h0D);
    watch(3, 8'h08);
    check({30'h0, seen[3], seen[0]}, 32'h3);
    fm.send_char(8'h0A);
    expect_ev(3, 8'h08, 1'b1);
    wreg(OFS_SCHAR, 32'h0000_0A00);
    fm.send_char(8'h0A);
    expect_ev(3, 8'h08, 1'b0);
    expect_at(9 * MS, 13 * MS, 8'h08);
    // alternate packing intervals
    wreg(OFS_SCHAR, 32'h0000_0A0D);
    wreg(OFS_FLUSH, 32'h80);
    for (int c = 0; c < 4; c++) begin
      wreg(OFS_PACK, c);
      fm.send_char(8'h0D);
      expect_ev(3, 8'h08, 1'b1);
      fm.send_char(8'h41);
      if (c < 3) expect_at((ivl[c] - 1) * MS, (ivl[c] + 1) * MS, 8'h08);
      else expect_ev(260 * MS, 8'h08, 1'b0);
    end
    // trailing characters after the send character
    for (int t = 0; t < 3; t++) begin
      wreg(OFS_PACK, (t << 2) | 3);
      fm.send_char(8'h0D);
      expect_ev(3, 8'h08, t == 0);
      for (int j = 0; j < t; j++) begin
        fm.send_char(8'h41);
        expect_ev(3, 8'h08, j == t - 1);
      end
    end
    // two-byte sequence, immediate send and control segments
    wreg(OFS_PACK, 32'h13);
    fm.send_char(8'h0A);
    expect_ev(3, 8'h08, 1'b0);
    fm.send_char(8'h0D);
    expect_ev(3, 8'h08, 1'b0);
    fm.send_char(8'h0A);
    expect_ev(3, 8'h08, 1'b1);
    for (int j = 0; j < 2; j++) begin
      wreg(OFS_PACK, j ? 32'h23 : 32'h03);
      fm.send_char(8'h0D);
      watch(3, 8'h08);
      check({30'h0, seen[3], seen[0]}, j ? 32'h2 : 32'h3);
    end
    fm.ctl_req();
    expect_ev(3, 8'h04, 1'b1);
    $display("test packing finished");
    // inactivity: characters keep the link, silence drops it
    wreg(OFS_TMO, 32'h2);
    for (int j = 0; j < 2; j++) begin
      expect_ev(600 * MS, 8'h40, 1'b0);
      fm.send_char(8'h41);
    end
    expect_at(990 * MS, 2010 * MS, 8'h40);
    wreg(OFS_TMO, 32'h0);
    // hard close: our drop, peer stays connected and never answers
    fm.close_conn(1'b1);
    for (int j = 0; j < 2; j++) begin
      wreg(OFS_DISC, j ? 32'h68 : 32'h60);
      fm.open_conn(1'b0);
      fm.send_char(EOT_CHAR);
      if (j == 0) expect_at(990 * MS, 1010 * MS, 8'h80);
      else expect_ev(1100 * MS, 8'h80, 1'b0);
      fm.close_conn(1'b0);
    end
    $display("test timers finished");
    report_and_stop();
  end
endmodule : serial_net_connection_packer_tb_top
